/* dac_host_model.sv */
// Purpose: host driving the three serial lines
// Assumes: 320 ns shift period, 8 system clocks
// Notes: lines rest low between frames
`timescale 1ns/1ps
module dac_host_model (
  // clock
  input wire logic clk_sys_i,
  // host lines
  output logic serial_in_o,
  output logic shift_clk_o,
  output logic load_strobe_o
);
  initial begin
    serial_in_o = 1'b0;
    shift_clk_o = 1'b0;
    load_strobe_o = 1'b0;
  end
  task send(input logic [11:0] w);
    for (int i = 11; i >= 0; i--) begin
      serial_in_o = w[i];
      repeat (2) @(negedge clk_sys_i);
      shift_clk_o = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      shift_clk_o = 1'b0;
      repeat (2) @(negedge clk_sys_i);
    end
    serial_in_o = 1'b0;
    load_strobe_o = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    load_strobe_o = 1'b0;
    repeat (6) @(negedge clk_sys_i);
  endtask : send
endmodule : dac_host_model

/* dac_loader_defs.svh */
// Purpose: constants for the serial channel loader
// Assumes: 25 MHz system clock
// Notes: offsets of fields within the 12-bit word
`ifndef DAC_LOADER_DEFS_SVH
`define DAC_LOADER_DEFS_SVH
`define WORD_W 12
`define VALUE_W 8
`define ADDR_W 4
`define CHAN_N 12
`define VALUE_LSB 0
`define ADDR_LSB 8
`define CHAN_FIRST 4'h1
`define CHAN_LAST 4'hC
`define VALUE_RST 8'h00
`define SHIFT_RST 12'h000
`endif

/* dac_loader_pkg.sv */
// Purpose: types for the serial channel loader
// Assumes: constants come from dac_loader_defs.svh
// Notes: word layout, address field in the top bits
`include "dac_loader_defs.svh"
package dac_loader_pkg;
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`VALUE_W-1:0] value;
  } ctrl_word_t;
  typedef logic [`CHAN_N-1:0][`VALUE_W-1:0] chan_bank_t;
endpackage : dac_loader_pkg

/* serial_dac_channel_loader.sv */
// Purpose: serial front end loading twelve 8-bit channel values
// Assumes: host pins asynchronous to clk_sys_i, shift rate well below clock
// Notes: pins pass three flops; edge counts when stages two and three agree
// Function
// - each shift-clock rising edge shifts serial_in into 12-bit register
// - serial output shows most significant shift register stage
// - load strobe high copies value field to addressed channel; decoder reads shift word at all times
// - word is four-bit address plus eight-bit value
// - twelve independent 8-bit channel values, each on own output
// - bits zero to seven are unsigned value, zero lowest
// - codes 1 to 12 select channels; others select nothing
`timescale 1ns/1ps
`include "dac_loader_defs.svh"
module serial_dac_channel_loader (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // host serial link
  input wire logic serial_in_i,
  input wire logic shift_clk_i,
  input wire logic load_strobe_i,
  output logic serial_out_o,
  // converter values
  output dac_loader_pkg::chan_bank_t channel_analog_out_o
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] din_sync_r;
  logic [2:0] sck_sync_r;
  logic [2:0] ld_sync_r;
  logic sck_lvl_r;
  logic ld_lvl_r;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      // idle level of the lines, so no false edge after reset
      din_sync_r <= 3'h0;
      sck_sync_r <= 3'h0;
      ld_sync_r <= 3'h0;
    end else begin
      din_sync_r <= {din_sync_r[1:0], serial_in_i};
      sck_sync_r <= {sck_sync_r[1:0], shift_clk_i};
      ld_sync_r <= {ld_sync_r[1:0], load_strobe_i};
    end
  end

  wire sck_agree = (sck_sync_r[1] == sck_sync_r[2]);
  wire ld_agree = (ld_sync_r[1] == ld_sync_r[2]);

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sck_lvl_r <= 1'b0;
      ld_lvl_r <= 1'b0;
    end else begin
      if (sck_agree) sck_lvl_r <= sck_sync_r[2];
      if (ld_agree) ld_lvl_r <= ld_sync_r[2];
    end
  end

  wire sck_rise = sck_agree && sck_sync_r[2] && !sck_lvl_r;
  wire ld_high = ld_agree ? ld_sync_r[2] : ld_lvl_r;

  // ----------------------------------------
  // shift register
  // ----------------------------------------
  logic [`WORD_W-1:0] shift_r;
  logic [`WORD_W-1:0] shift_nxt;

  assign shift_nxt = sck_rise ? {shift_r[`WORD_W-2:0], din_sync_r[2]} : shift_r;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) shift_r <= `SHIFT_RST;
    else shift_r <= shift_nxt;
  end

  assign serial_out_o = shift_r[`WORD_W-1];

  // ----------------------------------------
  // address decode and channel load
  // ----------------------------------------
  // address field arrives with word bit eight as the top code bit
  function automatic logic [`ADDR_W-1:0] addr_code(input logic [`ADDR_W-1:0] field);
    return {field[0], field[1], field[2], field[3]};
  endfunction : addr_code

  function automatic logic [`CHAN_N-1:0] chan_decode(input logic [`ADDR_W-1:0] code);
    logic [`CHAN_N-1:0] sel;
    sel = '0;
    // code 0 and 13..15 select nothing
    if (code >= `CHAN_FIRST && code <= `CHAN_LAST) sel[code - 4'h1] = 1'b1;
    return sel;
  endfunction : chan_decode

  dac_loader_pkg::ctrl_word_t word_w;
  logic [`ADDR_W-1:0] addr_w;
  logic [`CHAN_N-1:0] chan_sel;
  dac_loader_pkg::chan_bank_t chan_r;

  assign word_w = shift_r;
  assign addr_w = addr_code(word_w.addr);
  assign chan_sel = chan_decode(addr_w);

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < `CHAN_N; i++) begin
        chan_r[i] <= `VALUE_RST;
      end
    end else begin
      for (int i = 0; i < `CHAN_N; i++) begin
        if (ld_high && chan_sel[i]) begin
          chan_r[i] <= word_w.value;
        end
      end
    end
  end

  assign channel_analog_out_o = chan_r;

  // ----------------------------------------
  // checks: shift path
  // ----------------------------------------
  a_shift_on_edge: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sck_rise |=> shift_r == {$past(shift_r[`WORD_W-2:0]), $past(din_sync_r[2])})
    else $error("shift not taken on edge");

  a_shift_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !sck_rise |=> $stable(shift_r))
    else $error("shift moved without edge");

  a_one_shift_edge: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sck_rise
    |=> !sck_rise)
    else $error("one pin edge shifted twice");

  a_rise_sets_level: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sck_rise
    |=> sck_lvl_r)
    else $error("filtered shift level not raised");

  a_shift_level: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sck_agree
    |=> sck_lvl_r == $past(sck_sync_r[2]))
    else $error("filtered shift level wrong");

  a_reset_shift: assert property (@(posedge clk_sys_i)
    !rstn_i
    |=> shift_r == `SHIFT_RST)
    else $error("shift register not cleared");

  a_out_msb: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sck_rise |=> serial_out_o == $past(shift_r[`WORD_W-2]))
    else $error("serial out not msb");

  a_out_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !sck_rise
    |=> $stable(serial_out_o))
    else $error("serial out moved without edge");

  a_reset_out: assert property (@(posedge clk_sys_i)
    !rstn_i
    |=> !serial_out_o)
    else $error("serial out not cleared");

  // ----------------------------------------
  // checks: load path
  // ----------------------------------------
  a_load_chan: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ld_high && addr_w == 4'h3) |=> chan_r[2] == $past(shift_r[7:0]))
    else $error("channel three not loaded");

  a_load_any: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ld_high && addr_w >= `CHAN_FIRST && addr_w <= `CHAN_LAST)
    |=> channel_analog_out_o[$past(addr_w) - 4'h1] == $past(word_w.value))
    else $error("addressed channel not loaded");

  a_strobe_level: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ld_agree
    |=> ld_lvl_r == $past(ld_sync_r[2]))
    else $error("filtered strobe level wrong");

  a_no_load_low: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !ld_high |=> $stable(chan_r))
    else $error("channel changed without strobe");

  a_others_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ld_high && addr_w == 4'h1)
    |=> channel_analog_out_o[11:1] == $past(channel_analog_out_o[11:1]))
    else $error("unaddressed channel changed");

  a_reset_chan: assert property (@(posedge clk_sys_i)
    !rstn_i
    |=> channel_analog_out_o == '0)
    else $error("channels not cleared");

  a_value_map: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ld_high && addr_w == 4'hC) |=> channel_analog_out_o[11] == $past(shift_r[7:0]))
    else $error("value bits misplaced");

  a_first_value: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ld_high && addr_w == 4'h1)
    |=> channel_analog_out_o[0] == $past(shift_r[7:0]))
    else $error("first channel value misplaced");

  // ----------------------------------------
  // checks: address decode
  // ----------------------------------------
  a_bad_addr_none: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (addr_w == 4'h0 || addr_w > 4'hC) |=> $stable(chan_r))
    else $error("invalid address loaded a channel");

  a_one_chan_sel: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $onehot0(chan_sel))
    else $error("more than one channel selected");

  a_decode_map: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (addr_w >= `CHAN_FIRST && addr_w <= `CHAN_LAST)
    |-> chan_sel == (12'h001 << (addr_w - 4'h1)))
    else $error("wrong channel selected");

  a_decode_none: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (addr_w == 4'h0 || addr_w > `CHAN_LAST)
    |-> chan_sel == 12'h000)
    else $error("reserved code selected a channel");

  a_code_order: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    shift_r[8]
    |-> addr_w[3])
    else $error("word bit eight not code top bit");

endmodule : serial_dac_channel_loader

/* test_serial_dac_channel_loader.sv */
// Purpose: self-checking bench for the channel loader
// Assumes: rows hold {expected index, word}, F means no channel
// Notes: address code read with bit eight as its top bit
`timescale 1ns/1ps
module test_serial_dac_channel_loader;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic serial_in, shift_clk, load_strobe, serial_out_o;
  dac_loader_pkg::chan_bank_t chans;
  dac_loader_pkg::chan_bank_t exp_bank = '0;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [15:0] rows [9] = '{16'h08FF, 16'hB301, 16'hF0AA, 16'hFB55, 16'h1480, 16'h2C3C,
    16'h32A5, 16'hFF77, 16'h0800};
  always #20 clk_sys_i = ~clk_sys_i;
  dac_host_model host_u (.clk_sys_i(clk_sys_i), .serial_in_o(serial_in),
    .shift_clk_o(shift_clk), .load_strobe_o(load_strobe));
  serial_dac_channel_loader dut_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .serial_in_i(serial_in), .shift_clk_i(shift_clk), .load_strobe_i(load_strobe),
    .serial_out_o(serial_out_o), .channel_analog_out_o(chans));
  task check(input logic [95:0] seen, input logic [95:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    for (int r = 0; r < 9; r++) begin
      host_u.send(rows[r][11:0]);
      if (rows[r][15:12] != 4'hF) exp_bank[rows[r][15:12]] = rows[r][7:0];
      check(chans, exp_bank);
      check(serial_out_o, rows[r][11]);
      $display("row %0d done", r);
    end
    rstn_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    exp_bank = '0;
    check(chans, exp_bank);
    check(serial_out_o, 1'b0);
    $display("mid-run reset done");
    rstn_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    host_u.send(rows[1][11:0]);
    exp_bank[11] = rows[1][7:0];
    check(chans, exp_bank);
    $display("reset release done");
    summarize();
  end
endmodule : test_serial_dac_channel_loader
